//--- hdl/jtp_tap.sv
`timescale 1ns/1ps
`default_nettype none
module jtp_tap
  import jtp_pkg::*;
(
  // System
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            busActive,
  // Test port pins
  input  wire jtp_link_t       link,
  output logic                 tdo,
  output logic                 tdoEn,
  // Functional pins (driver values core to pad, pad levels pad to core)
  input  wire jtp_pins_t       coreOut,
  input  wire logic [BSR_W-1:0] padIn,
  output jtp_pins_t            padOut,
  output logic [BSR_W-1:0]     coreIn,
  // Internal test chains
  output logic                 scanIn,
  output logic                 scanShift,
  input  wire logic            scanOut,
  output logic                 memSelftestIn,
  output logic                 memSelftestShift,
  input  wire logic            memSelftestOut
);

  // Two-flop synchronisers; only the second stage is read.
  logic [2:0] linkS1_r;
  logic [2:0] linkS2_r;
  logic       tckD_r;
  logic [BSR_W-1:0] padS1_r;
  logic [BSR_W-1:0] padS2_r;
  logic       busS1_r;
  logic       busS2_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkS1_r <= 3'h0;
      linkS2_r <= 3'h0;
      tckD_r   <= 1'b0;
      padS1_r  <= '0;
      padS2_r  <= '0;
      busS1_r  <= 1'b0;
      busS2_r  <= 1'b0;
    end else begin
      linkS1_r <= {link.tck, link.tms, link.tdi};
      linkS2_r <= linkS1_r;
      tckD_r   <= linkS2_r[2];
      padS1_r  <= padIn;
      padS2_r  <= padS1_r;
      busS1_r  <= busActive;
      busS2_r  <= busS1_r;
    end
  end

  logic tms;
  logic tdi;
  logic rise;
  logic fall;
  assign tms  = linkS2_r[1];
  assign tdi  = linkS2_r[0];
  // Rising edges are ignored while bus cycles run, so the tester cannot disturb traffic.
  assign rise = linkS2_r[2] & ~tckD_r & ~busS2_r;
  assign fall = ~linkS2_r[2] & tckD_r;

  function automatic jtp_path_t decodePath(input logic [IR_W-1:0] ins);
    case (ins)
      INS_EXTEST, INS_SAMPLE: decodePath = SEL_BSR;
      INS_IDCODE:             decodePath = SEL_ID;
      INS_INTSCAN:            decodePath = SEL_INTSCAN;
      INS_MEMTEST:            decodePath = SEL_MEM;
      default:                decodePath = SEL_BYPASS;
    endcase
  endfunction : decodePath

  jtp_state_t state_r;
  jtp_state_t state_nxt;

  always_comb begin
    case (state_r)
      ST_RESET:   state_nxt = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:    state_nxt = tms ? ST_SELDR  : ST_IDLE;
      ST_SELDR:   state_nxt = tms ? ST_SELIR  : ST_CAPDR;
      ST_CAPDR:   state_nxt = tms ? ST_EX1DR  : ST_SHDR;
      ST_SHDR:    state_nxt = tms ? ST_EX1DR  : ST_SHDR;
      ST_EX1DR:   state_nxt = tms ? ST_UPDDR  : ST_PAUSEDR;
      ST_PAUSEDR: state_nxt = tms ? ST_EX2DR  : ST_PAUSEDR;
      ST_EX2DR:   state_nxt = tms ? ST_UPDDR  : ST_SHDR;
      ST_UPDDR:   state_nxt = tms ? ST_SELDR  : ST_IDLE;
      ST_SELIR:   state_nxt = tms ? ST_RESET  : ST_CAPIR;
      ST_CAPIR:   state_nxt = tms ? ST_EX1IR  : ST_SHIR;
      ST_SHIR:    state_nxt = tms ? ST_EX1IR  : ST_SHIR;
      ST_EX1IR:   state_nxt = tms ? ST_UPDIR  : ST_PAUSEIR;
      ST_PAUSEIR: state_nxt = tms ? ST_EX2IR  : ST_PAUSEIR;
      ST_EX2IR:   state_nxt = tms ? ST_UPDIR  : ST_SHIR;
      ST_UPDIR:   state_nxt = tms ? ST_SELDR  : ST_IDLE;
      default:    state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else if (rise) begin
      state_r <= state_nxt;
    end
  end

  // Instruction shift and active registers.
  logic [IR_W-1:0] irShift_r;
  logic [IR_W-1:0] ir_r;
  jtp_path_t       path;
  assign path = decodePath(ir_r);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irShift_r <= '0;
      ir_r      <= INS_IDCODE;
    end else if (rise) begin
      case (state_r)
        ST_RESET: ir_r <= INS_IDCODE;
        ST_CAPIR: irShift_r <= {{(IR_W-2){1'b0}}, IR_CAPTURE};
        ST_SHIR:  irShift_r <= {tdi, irShift_r[IR_W-1:1]};
        ST_UPDIR: ir_r <= irShift_r;
        default:  ir_r <= ir_r;
      endcase
    end
  end

  // Data registers.
  logic             bypass_r;
  logic [ID_W-1:0]  idShift_r;
  logic [BSR_W-1:0] bsrShift_r;
  logic [BSR_W-1:0] bsrHold_r;
  logic [BSR_W-1:0] bsrEnShift_r;
  logic [BSR_W-1:0] bsrEnHold_r;
  logic             capture;
  logic             shiftDr;
  assign capture = rise && state_r == ST_CAPDR;
  assign shiftDr = rise && state_r == ST_SHDR;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_r <= 1'b0;
    end else if (capture && path == SEL_BYPASS) begin
      bypass_r <= 1'b0;
    end else if (shiftDr && path == SEL_BYPASS) begin
      bypass_r <= tdi;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idShift_r <= '0;
    end else if (capture && path == SEL_ID) begin
      idShift_r <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    end else if (shiftDr && path == SEL_ID) begin
      idShift_r <= {tdi, idShift_r[ID_W-1:1]};
    end
  end

  // Boundary chain: enable cells then value cells, data in to data out.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bsrShift_r   <= '0;
      bsrEnShift_r <= '0;
      bsrHold_r    <= '0;
      bsrEnHold_r  <= '0;
    end else begin
      if (capture && path == SEL_BSR) begin
        // Output cells see the driver values, input cells the pads.
        bsrShift_r   <= (coreOut.enable & coreOut.value) | (~coreOut.enable & padS2_r);
        bsrEnShift_r <= coreOut.enable;
      end else if (shiftDr && path == SEL_BSR) begin
        bsrEnShift_r <= {tdi, bsrEnShift_r[BSR_W-1:1]};
        bsrShift_r   <= {bsrEnShift_r[0], bsrShift_r[BSR_W-1:1]};
      end
      if (rise && state_r == ST_UPDDR && path == SEL_BSR) begin
        bsrHold_r   <= bsrShift_r;
        bsrEnHold_r <= bsrEnShift_r;
      end
      if (rise && state_r == ST_RESET) begin
        bsrHold_r   <= '0;
        bsrEnHold_r <= '0;
      end
    end
  end

  // Pin muxing, registered so every output comes from a flip-flop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      padOut <= '0;
      coreIn <= '0;
    end else begin
      case (ir_r)
        INS_EXTEST: begin
          padOut <= '{value: bsrHold_r, enable: bsrEnHold_r};
          coreIn <= bsrHold_r;
        end
        INS_CLAMP: begin
          padOut <= '{value: bsrHold_r, enable: bsrEnHold_r};
          coreIn <= padS2_r;
        end
        INS_HIGHZ: begin
          padOut <= '{value: '0, enable: '0};
          coreIn <= padS2_r;
        end
        default: begin
          padOut <= coreOut;
          coreIn <= padS2_r;
        end
      endcase
    end
  end

  // Internal chains are clocked one bit per rising test clock during Shift-DR.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scanIn           <= 1'b0;
      scanShift        <= 1'b0;
      memSelftestIn    <= 1'b0;
      memSelftestShift <= 1'b0;
    end else begin
      scanIn           <= tdi;
      memSelftestIn    <= tdi;
      scanShift        <= shiftDr && path == SEL_INTSCAN;
      memSelftestShift <= shiftDr && path == SEL_MEM;
    end
  end

  logic serialOut;
  always_comb begin
    if (state_r == ST_SHIR) begin
      serialOut = irShift_r[0];
    end else begin
      case (path)
        SEL_BSR:     serialOut = bsrShift_r[0];
        SEL_ID:      serialOut = idShift_r[0];
        SEL_INTSCAN: serialOut = scanOut;
        SEL_MEM:     serialOut = memSelftestOut;
        default:     serialOut = bypass_r;
      endcase
    end
  end

  // Updated on the falling edge so the tester samples a settled value.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else if (fall) begin
      tdo   <= serialOut;
      tdoEn <= state_r == ST_SHIR || state_r == ST_SHDR;
    end
  end

endmodule : jtp_tap
`default_nettype wire

//--- hdl/jtp_pkg.sv
// Notes on behaviour
// - Test port uses four pins: clock, data in, data out, mode select.
// - Every functional pin other than test pins sits in the boundary chain.
// - Controller is a sixteen-state machine advancing on test clock, steered by mode select.
// - Power-on reset forces the controller into Test-Logic-Reset.
// - Test port is ignored while the bridge runs bus cycles; code drops rising test clocks only, falling ones still update data out.
// - Test logic holds controller, instruction register, bypass and boundary registers.
// - Five-bit instruction register selects data path and pin behaviour.
// - Code 11111 and undefined codes act as bypass.
// - Code 00000 selects boundary register, drives outputs, captures inputs.
// - Code 00001 samples pins and preloads cells; pins work normally.
// - Code 00101 tri-states all outputs and selects bypass.
// - Code 00100 drives pins from boundary register, shifts bypass.
// - Code 01100 selects the 32-bit identification register.
// - Code 00010 selects internal scan; 01010 selects memory self-test path.
// - Bypass register is one bit, shortest path data in to data out.
// - Identification: version 31:28, part 27:12, maker 11:1, bit 0 one.
// - Under external test and sample, cells capture pins on rising test clock.
// - Power, ground and test pins are excluded; chain runs data in to out.
package jtp_pkg;
  localparam int IR_W  = 5;
  localparam int BSR_W = 8;
  localparam int ID_W  = 32;
  localparam logic [IR_W-1:0] INS_EXTEST   = 5'h00;
  localparam logic [IR_W-1:0] INS_SAMPLE   = 5'h01;
  localparam logic [IR_W-1:0] INS_INTSCAN  = 5'h02;
  localparam logic [IR_W-1:0] INS_CLAMP    = 5'h04;
  localparam logic [IR_W-1:0] INS_HIGHZ    = 5'h05;
  localparam logic [IR_W-1:0] INS_MEMTEST  = 5'h0A;
  localparam logic [IR_W-1:0] INS_IDCODE   = 5'h0C;
  localparam logic [IR_W-1:0] INS_BYPASS   = 5'h1F;
  localparam logic [1:0]      IR_CAPTURE   = 2'h1;
  // Identity fields are arbitrary neutral values.
  localparam logic [3:0]  ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART    = 16'h0ABC;
  localparam logic [10:0] ID_MAKER   = 11'h055;
  typedef enum {
    ST_RESET, ST_IDLE, ST_SELDR, ST_CAPDR, ST_SHDR, ST_EX1DR, ST_PAUSEDR, ST_EX2DR,
    ST_UPDDR, ST_SELIR, ST_CAPIR, ST_SHIR, ST_EX1IR, ST_PAUSEIR, ST_EX2IR, ST_UPDIR
  } jtp_state_t;
  typedef enum {SEL_BYPASS, SEL_BSR, SEL_ID, SEL_INTSCAN, SEL_MEM} jtp_path_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_link_t;
  typedef struct packed {
    logic [BSR_W-1:0] value;
    logic [BSR_W-1:0] enable;
  } jtp_pins_t;
endpackage : jtp_pkg

//--- bench/jtp_tester.sv
`timescale 1ns/1ps
`default_nettype none
module jtp_tester
  import jtp_pkg::*;
(
  // Test port
  output var jtp_link_t link,
  input  wire logic      tdo,
  input  wire logic      tdoEn
);
  // The clock rests low between frames, so the block sees no stray edges.
  initial link = '0;
  // Inputs move only while the clock is low, half a period before each rise.
  task automatic step(input logic m, input logic d, output logic o);
    link.tms = m;
    link.tdi = d;
    #62.5;
    // A released data-out line floats to the pull-up, so a late enable reads as ones.
    o = tdoEn ? tdo : 1'b1;
    link.tck = 1'b1;
    #62.5;
    link.tck = 1'b0;
  endtask : step
endmodule : jtp_tester
`default_nettype wire

//--- bench/jtp_tap_chk.sv
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_chk
  import jtp_pkg::*;
(
  // System
  input wire logic      sys_clk,
  input wire logic      rst_n,
  input wire logic      busActive,
  // Test port
  input wire jtp_link_t link,
  input wire logic      tdo,
  input wire logic      tdoEn,
  // Chains
  input wire logic      scanIn,
  input wire logic      scanShift,
  input wire logic      memSelftestIn,
  input wire logic      memSelftestShift
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic anyShift;
  assign anyShift = scanShift | memSelftestShift;
  sequence s_bus;
    busActive [*5];
  endsequence
  sequence s_tdi;
    $stable(link.tdi) [*5];
  endsequence
  property p_rst; $rose(rst_n) |-> !tdo && !tdoEn; endproperty
  property p_excl; !(scanShift && memSelftestShift); endproperty
  property p_pulse; anyShift |=> !anyShift; endproperty
  property p_after; anyShift |-> $past(link.tck, 2); endproperty
  property p_tdo; !$stable(tdo) |-> !link.tck; endproperty
  property p_en; !$stable(tdoEn) |-> !link.tck; endproperty
  property p_bus; s_bus |-> !anyShift; endproperty
  property p_copy; s_tdi |-> scanIn == link.tdi && memSelftestIn == link.tdi; endproperty
  property p_shen; anyShift |-> tdoEn; endproperty
  a_rst: assert property (p_rst) else $error("port active after reset");
  a_excl: assert property (p_excl) else $error("two chains shift");
  a_pulse: assert property (p_pulse) else $error("shift pulse too long");
  a_after: assert property (p_after) else $error("shift without clock rise");
  a_tdo: assert property (p_tdo) else $error("tdo moved with clock high");
  a_en: assert property (p_en) else $error("tdoEn moved with clock high");
  a_bus: assert property (p_bus) else $error("shift during bus cycles");
  a_copy: assert property (p_copy) else $error("chain input not tdi");
  a_shen: assert property (p_shen) else $error("shift with tdo off");
endmodule : jtp_tap_chk
bind jtp_tap jtp_tap_chk jtp_tap_chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .busActive(busActive), .link(link), .tdo(tdo),
  .tdoEn(tdoEn), .scanIn(scanIn), .scanShift(scanShift), .memSelftestIn(memSelftestIn),
  .memSelftestShift(memSelftestShift)
);
`default_nettype wire

//--- bench/jtp_tap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_tb;
  import jtp_pkg::*;
  logic             sys_clk, rst_n, busActive, tdo, tdoEn, scanIn, scanShift, scanOut;
  logic             memSelftestIn, memSelftestShift, memSelftestOut;
  jtp_link_t        link;
  jtp_pins_t        coreOut, padOut, pre;
  logic [BSR_W-1:0] padIn, coreIn;
  logic [31:0]      d;
  int               fails, cmp_count, cyc, nScan, nMem;
  jtp_tap jtp_tap_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .busActive(busActive), .link(link), .tdo(tdo),
    .tdoEn(tdoEn), .coreOut(coreOut), .padIn(padIn), .padOut(padOut), .coreIn(coreIn),
    .scanIn(scanIn), .scanShift(scanShift), .scanOut(scanOut), .memSelftestIn(memSelftestIn),
    .memSelftestShift(memSelftestShift), .memSelftestOut(memSelftestOut)
  );
  jtp_tester jtp_tester_i (.link(link), .tdo(tdo), .tdoEn(tdoEn));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (scanShift === 1'b1) nScan++;
    if (memSelftestShift === 1'b1) nMem++;
    if (cyc == 10000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic walk(input logic [7:0] tms, input int n);
    logic o;
    for (int i = 0; i < n; i++) jtp_tester_i.step(tms[i], 1'b0, o);
    #60;
  endtask : walk
  // Shift n bits LSB first, then pass Update back to Idle.
  task automatic shift(input int n, input logic [31:0] din);
    logic o;
    d = '0;
    for (int i = 0; i < n; i++) begin
      jtp_tester_i.step(i == n - 1, din[i], o);
      d[i] = o;
    end
    walk(8'h01, 2);
  endtask : shift
  task automatic ir(input logic [IR_W-1:0] code);
    walk(8'h03, 4);
    shift(IR_W, 32'(code));
  endtask : ir
  task automatic dr(input int n, input logic [31:0] din);
    walk(8'h01, 3);
    shift(n, din);
  endtask : dr
  task automatic t_idcode;
    walk(8'h00, 1);
    dr(ID_W, '0);
    chk("idcode", d, {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
  endtask : t_idcode
  task automatic t_preload;
    pre = '{value: 8'h96, enable: 8'hF0};
    ir(INS_SAMPLE);
    chk("ircapture", d, 32'h01);
    dr(2 * BSR_W, {pre.enable, pre.value});
    // Driven pins show the core value, undriven pins the pad level.
    chk("capture", d, 32'h5A39);
    chk("sample", padOut, coreOut);
    chk("samplecore", coreIn, padIn);
    ir(INS_EXTEST);
    chk("extest", padOut, pre);
    chk("extestcore", coreIn, pre.value);
  endtask : t_preload
  task automatic t_bypass;
    logic [IR_W-1:0] codes[4] = '{INS_BYPASS, 5'h15, INS_HIGHZ, INS_CLAMP};
    foreach (codes[k]) begin
      ir(codes[k]);
      dr(8, 32'hA5);
      chk("bypass", d, 32'h4A);
      if (k == 2) chk("highz", padOut.enable, 32'h0);
      if (k == 3) chk("clamp", padOut, pre);
    end
  endtask : t_bypass
  task automatic t_chains;
    for (int k = 0; k < 2; k++) begin
      // Only the selected chain returns ones, so a wrong path reads zeros.
      scanOut = (k == 0);
      memSelftestOut = (k == 1);
      ir(k ? INS_MEMTEST : INS_INTSCAN);
      nScan = 0;
      nMem = 0;
      dr(8, '0);
      chk("chainout", d, 32'hFF);
      chk("pulses", k ? nMem : nScan, 8);
      chk("idle", k ? nScan : nMem, 0);
    end
  endtask : t_chains
  task automatic t_bus;
    walk(8'h1F, 6);
    ir(INS_INTSCAN);
    @(posedge sys_clk);
    #1 busActive = 1'b1;
    nScan = 0;
    // These edges would reach Shift-DR and shift once if they were taken.
    walk(8'h01, 4);
    @(posedge sys_clk);
    #1 busActive = 1'b0;
    chk("busidle", tdoEn, 0);
    chk("busscan", nScan, 0);
    walk(8'h01, 3);
    chk("shiften", tdoEn, 1);
    walk(8'h1F, 5);
    t_idcode();
  endtask : t_bus
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    rst_n = 1'b0;
    busActive = 1'b0;
    coreOut = 16'h3C5A;
    padIn = 8'h69;
    scanOut = 1'b1;
    memSelftestOut = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    // Link edges then never coincide with a system clock edge.
    #1;
    chk("rsten", tdoEn, 0);
    t_idcode();
    t_preload();
    t_bypass();
    t_chains();
    t_bus();
    wrap_up();
  end
endmodule : jtp_tap_tb
`default_nettype wire
